// >>> common/ddr2_pin_defs.svh
// Bit positions, reset values, burst codes and pair counts of the DDR2 device pin logic.
`ifndef DDR2_PIN_DEFS_SVH
`define DDR2_PIN_DEFS_SVH

`define PRECHARGE_ALL_BIT      10
`define AUTO_PRECHARGE_BIT     10
`define MASK_OR_RSTROBE_BIT    11
`define STROBE_COMP_OFF_BIT    10
`define TERM_LOW_BIT           2
`define TERM_HIGH_BIT          6
`define BURST_FIELD_MSB        2
`define BURST_FIELD_LSB        0
`define BURST_EIGHT_CODE       3'h3
`define PAIRS_BURST_FOUR       3'h2
`define PAIRS_BURST_EIGHT      3'h4
`define MODE_REG_RESET         14'h0000

`endif

// >>> common/ddr2_pin_pkg.sv
// Types shared by the DDR2 device pin logic.
package ddr2_pin_pkg;

  // Code is {chip select, row strobe, column strobe, write enable}, all active low.
  typedef enum logic [3:0]
  {
    CMD_MODE_SET  = 4'h0,
    CMD_REFRESH   = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE  = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_READ      = 4'h5,
    CMD_TERMINATE = 4'h6,
    CMD_NOP       = 4'h7,
    CMD_DESELECT  = 4'h8
  } command_type;

  typedef enum logic [1:0]
  {
    LINK_IDLE       = 2'b00,
    LINK_WRITE_LEAD = 2'b01,
    LINK_WRITE      = 2'b11,
    LINK_READ       = 2'b10
  } link_phase_type;

endpackage

// >>> tb/ddr2_ctrl_model.sv
// Behavioural memory controller driving the device command and write data pins.
`timescale 1ns/10ps
module ddr2_ctrl_model
(
  input  wire logic        diff_clock_in,
  output logic             chip_select_n,
  output logic             row_strobe_n,
  output logic             column_strobe_n,
  output logic             write_enable_n,
  output logic             clock_enable,
  output logic             termination_enable,
  output logic [1:0]       bank_select,
  output logic [13:0]      address_lines,
  output logic [15:0]      data_lines_in,
  output logic [1:0]       write_mask
);
  initial
  begin
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hF;
    clock_enable = 1'b1;
    termination_enable = 1'b0;
    bank_select = 2'h0;
    address_lines = 14'h0000;
    data_lines_in = 16'h0000;
    write_mask = 2'h0;
  end

  // Code is {clock enable low, chip select, row, column, write}; held for one rise.
  task automatic issue(input logic [4:0] c, input logic [1:0] b, input logic [13:0] a,
                       input int gap);
    repeat (gap + 1) @(posedge diff_clock_in);
    #1;
    clock_enable = !c[4];
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = c[3:0];
    bank_select = b;
    address_lines = a;
    @(posedge diff_clock_in);
    #1;
    clock_enable = 1'b1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
    bank_select = ~b;
    address_lines = ~a;
  endtask

  // Each beat changes just after the opposite edge so it is centred on its sampling edge.
  task automatic beats(input logic [15:0] d [8], input logic [1:0] m [8], input int n);
    for (int k = 0; k < n; k++)
    begin
      data_lines_in = d[k];
      write_mask = m[k];
      if (k % 2 == 0)
        @(negedge diff_clock_in);
      else
        @(posedge diff_clock_in);
      #1;
    end
    data_lines_in = ~data_lines_in;
    write_mask = ~write_mask;
  endtask

  task automatic set_term(input logic v);
    @(posedge diff_clock_in);
    #1;
    termination_enable = v;
  endtask
endmodule // ddr2_ctrl_model

// >>> tb/ddr2_pin_device_props.sv
// Link-domain assertions on the DDR2 device pins.
`timescale 1ns/10ps
module ddr2_pin_device_props
#(
  parameter int DATA_WIDTH = 16,
  parameter int ADDR_WIDTH = 14
)
(
  input wire logic                    diff_clock_in,
  input wire logic                    sys_rst,
  input wire logic                    chip_select_n,
  input wire logic                    row_strobe_n,
  input wire logic                    column_strobe_n,
  input wire logic                    write_enable_n,
  input wire logic                    clock_enable,
  input wire logic                    termination_enable,
  input wire logic [1:0]              bank_select,
  input wire logic [ADDR_WIDTH-1:0]   address_lines,
  input wire logic                    data_lines_oe,
  input wire logic [DATA_WIDTH/8-1:0] data_strobe_out,
  input wire logic [DATA_WIDTH/8-1:0] data_strobe_oe,
  input wire logic [DATA_WIDTH/8-1:0] data_strobe_comp_oe,
  input wire logic                    termination_on,
  input wire logic [3:0]              bank_row_open,
  input wire logic [ADDR_WIDTH-1:0]   extended_mode_reg_one
);
  logic [2:0]            op;
  logic                  take;
  logic [2:0]            gap_reg;
  logic [ADDR_WIDTH-1:0] mr;
  assign op   = {row_strobe_n, column_strobe_n, write_enable_n};
  assign take = !chip_select_n && clock_enable;
  assign mr   = extended_mode_reg_one;

  // Burst checks only after a quiet gap long enough for a burst of four pairs to end.
  // A read or write that lands inside a running burst is dropped and must not be checked.
  always_ff @(posedge diff_clock_in or posedge sys_rst)
    if (sys_rst)
      gap_reg <= 3'h0;
    else if (take && op[2:1] == 2'b10)
      gap_reg <= 3'h0;
    else if (gap_reg != 3'h7)
      gap_reg <= gap_reg + 3'h1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge diff_clock_in);
  endclocking
  default disable iff (sys_rst);

  AST_TERM_ON: assert property (
    (mr[2] || mr[6]) && termination_enable ##1 $stable(mr) |-> termination_on)
    else $error("termination not switched on");
  AST_TERM_OFF: assert property (
    !(mr[2] || mr[6]) ##1 $stable(mr) |-> !termination_on)
    else $error("termination on while disabled");
  AST_CS_MASK: assert property (
    !take |=> $stable(bank_row_open) && $stable(mr))
    else $error("masked command changed state");
  AST_ACT: assert property (
    take && op == 3'b011 |=> bank_row_open[$past(bank_select)])
    else $error("activate did not open bank");
  AST_PRE_ALL: assert property (
    take && op == 3'b010 && address_lines[10] |=> bank_row_open == 4'h0)
    else $error("precharge all left a bank open");
  AST_PRE_ONE: assert property (
    take && op == 3'b010 && !address_lines[10]
    |=> bank_row_open == ($past(bank_row_open) & ~(4'h1 << $past(bank_select))))
    else $error("single precharge wrong bank");
  AST_EMR_WR: assert property (
    take && op == 3'b000 && bank_select == 2'h1 |=> mr == $past(address_lines))
    else $error("mode register one not written");
  AST_MRS_KEEP: assert property (
    take && op == 3'b000 && bank_select != 2'h1 |=> $stable(mr))
    else $error("other mode set changed register one");
  AST_COMP_OFF: assert property (
    mr[10] ##1 $stable(mr) |-> data_strobe_comp_oe == '0)
    else $error("complementary strobe driven while off");
  AST_READ: assert property (
    take && op == 3'b101 && gap_reg > 3'h4 |-> ##2 (data_lines_oe && &data_strobe_oe
    && &data_strobe_out && data_strobe_comp_oe == {(DATA_WIDTH/8){!$past(mr[10])}}))
    else $error("read burst did not start");
  AST_WRITE: assert property (
    take && op == 3'b100 && gap_reg > 3'h4 |-> ##2 (!data_lines_oe && data_strobe_oe == '0))
    else $error("device drove pins on write");

  COV_READ: cover property (take && op == 3'b101 && gap_reg > 3'h4);
  COV_PRE_ALL: cover property (take && op == 3'b010 && address_lines[10]);
  COV_TERM: cover property (termination_on);
endmodule // ddr2_pin_device_props

bind ddr2_pin_device ddr2_pin_device_props
#(
  .DATA_WIDTH (DATA_WIDTH),
  .ADDR_WIDTH (ADDR_WIDTH)
)
props_i
(
  .diff_clock_in, .sys_rst, .chip_select_n, .row_strobe_n, .column_strobe_n,
  .write_enable_n, .clock_enable, .termination_enable, .bank_select, .address_lines,
  .data_lines_oe, .data_strobe_out, .data_strobe_oe, .data_strobe_comp_oe,
  .termination_on, .bank_row_open, .extended_mode_reg_one
);

// >>> tb/ddr2_pin_device_tb_top.sv
// Self-checking bench for the DDR2 device pin logic.
`timescale 1ns/10ps
module ddr2_pin_device_tb_top;
  logic        clk, sys_rst, diff_clock_in, clock_enable, termination_enable;
  logic        chip_select_n, row_strobe_n, column_strobe_n, write_enable_n;
  logic [1:0]  bank_select, write_mask, data_strobe_out, data_strobe_oe, data_strobe_comp_oe;
  logic [13:0] address_lines, extended_mode_reg_one, cmd_address, emr_ref;
  logic [15:0] data_lines_in, data_lines_out_rise, data_lines_out_fall;
  logic        data_lines_oe, redundant_read_strobe_oe, termination_on, cmd_event, cmd_overrun;
  logic [3:0]  bank_row_open, cmd_code, open_ref, col;
  logic [1:0]  cmd_bank;
  logic [15:0] mem [16];
  logic [19:0] rep_exp [$];
  logic [19:0] rep_got [$];
  int          pairs, n_mismatch, comparisons, cycles;

  ddr2_pin_device ddr2_pin_device_i
  (
    .clk, .sys_rst, .diff_clock_in, .chip_select_n, .row_strobe_n, .column_strobe_n,
    .write_enable_n, .clock_enable, .termination_enable, .bank_select, .address_lines,
    .data_lines_in, .write_mask, .data_lines_out_rise, .data_lines_out_fall, .data_lines_oe,
    .data_strobe_out, .data_strobe_oe, .data_strobe_comp_oe, .redundant_read_strobe_oe,
    .termination_on, .bank_row_open, .extended_mode_reg_one, .cmd_event, .cmd_code,
    .cmd_bank, .cmd_address, .cmd_overrun
  );
  ddr2_ctrl_model ddr2_ctrl_model_i
  (
    .diff_clock_in, .chip_select_n, .row_strobe_n, .column_strobe_n, .write_enable_n,
    .clock_enable, .termination_enable, .bank_select, .address_lines, .data_lines_in,
    .write_mask
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial
  begin
    diff_clock_in = 1'b0;
    #1.3;
    forever #3 diff_clock_in = ~diff_clock_in;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cmd_event === 1'b1)
      rep_got.push_back({cmd_code, cmd_bank, cmd_address});
    if (cycles > 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A gap above zero leaves room for the report handshake, so those commands are expected.
  task automatic cmd(input logic [4:0] c, input logic [1:0] b, input logic [13:0] a,
                     input int gap);
    ddr2_ctrl_model_i.issue(c, b, a, gap);
    if (c[4:3] == 2'h0 && c[2:0] == 3'h0 && b == 2'h1) emr_ref = a;
    if (c[4:3] == 2'h0 && c[2:0] == 3'h0 && b == 2'h0) pairs = (a[2:0] == 3'h3) ? 4 : 2;
    if (c[4:3] == 2'h0 && c[2:0] == 3'h3) open_ref[b] = 1'b1;
    if (c[4:3] == 2'h0 && c[2:0] == 3'h2) open_ref = a[10] ? 4'h0 : open_ref & ~(4'h1 << b);
    if (c[4:3] == 2'h0 && c[2:1] == 2'b10 && a[10]) open_ref[b] = 1'b0;
    if (gap > 0 && c[4:3] == 2'h0 && c[2:0] != 3'h7) rep_exp.push_back({c[3:0], b, a});
    check(bank_row_open, open_ref);
    check(extended_mode_reg_one, emr_ref);
  endtask

  task automatic wr(input logic [3:0] c0, input bit masked);
    logic [15:0] d [8];
    logic [1:0]  m [8];
    for (int k = 0; k < 2 * pairs; k++)
    begin
      d[k] = 16'($urandom);
      m[k] = masked ? 2'($urandom) : 2'h0;
      if (!m[k][0]) mem[4'(c0 + k)][7:0] = d[k][7:0];
      if (!m[k][1]) mem[4'(c0 + k)][15:8] = d[k][15:8];
    end
    cmd(5'h04, 2'h0, {3'h0, 1'($urandom), 6'($urandom), c0}, 0);
    ddr2_ctrl_model_i.beats(d, m, 2 * pairs);
  endtask

  task automatic rd(input logic [3:0] c0);
    cmd(5'h05, 2'h0, {10'h000, c0}, 0);
    for (int k = 0; k < pairs; k++)
    begin
      @(posedge diff_clock_in);
      #1;
      check(data_lines_out_rise, mem[4'(c0 + 2 * k)]);
      check(data_lines_out_fall, mem[4'(c0 + 2 * k + 1)]);
      check({data_lines_oe, data_strobe_oe, data_strobe_out}, 5'h1F);
      check({redundant_read_strobe_oe, data_strobe_comp_oe}, {1'b0, {2{!emr_ref[10]}}});
    end
    @(posedge diff_clock_in);
    #1;
    check({data_lines_oe, data_strobe_oe}, 3'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    pairs = 2;
    open_ref = 4'h0;
    emr_ref = 14'h0000;
    void'($urandom(63));
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge diff_clock_in);
    for (int b = 0; b < 4; b++)
      cmd(5'h00, 2'(b), {11'($urandom), 3'h2}, 12);
    for (int b = 0; b < 4; b++)
      cmd(5'h03, 2'(b), 14'($urandom), 12);
    cmd(5'h0A, 2'h1, 14'h0400, 12);
    cmd(5'h12, 2'h1, 14'h0400, 12);
    cmd(5'h02, 2'h2, 14'h0000, 12);
    cmd(5'h02, 2'h0, 14'h0400, 12);
    cmd(5'h01, 2'h0, 14'h0000, 12);
    cmd(5'h06, 2'h0, 14'h0000, 12);
    cmd(5'h00, 2'h1, 14'h0004, 12);
    ddr2_ctrl_model_i.set_term(1'b1);
    repeat (2) @(posedge diff_clock_in);
    #1;
    check(termination_on, 1'b1);
    cmd(5'h00, 2'h1, 14'h0000, 12);
    repeat (2) @(posedge diff_clock_in);
    #1;
    check(termination_on, 1'b0);
    ddr2_ctrl_model_i.set_term(1'b0);
    repeat (20) @(posedge diff_clock_in);
    check(20'(rep_got.size()), 20'(rep_exp.size()));
    foreach (rep_exp[k]) check(rep_got[k], rep_exp[k]);
    check(cmd_overrun, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      cmd(5'h00, 2'h1, (p == 1) ? 14'h0400 : 14'h0000, 0);
      cmd(5'h00, 2'h0, (p == 1) ? 14'h0003 : 14'h0002, 0);
      cmd(5'h03, 2'h0, 14'($urandom), 0);
      col = 4'($urandom);
      wr(col, 1'b0);
      wr(col, 1'b1);
      rd(col);
    end
    check(cmd_overrun, 1'b1);
    end_of_test();
  end
endmodule // ddr2_pin_device_tb_top

// >>> verilog/ddr2_pin_device.sv
// DDR2 device pin logic: command decode, mode registers, termination, data and strobes.
//
// Functional notes
// - Registered termination input turns termination on.
// - Termination disabled in register one ignores input.
// - Command decoded from strobes and chip select.
// - Chip select high masks every command.
// - Address and control sampled on rising clock.
// - Mask sampled with each beat, both edges.
// - Byte-wide mask active only when register enables.
// - Bank select names bank of access commands.
// - Bank select picks mode register to write.
// - Active takes row; read/write take column.
// - Precharge bit high closes all banks.
// - Mode set op-code taken from address.
// - Device drives strobe on reads, controller writes.
// - Register bit disables all complementary strobes.
// - Byte-wide redundant read strobe when enabled.
// - Lower strobe qualifies low data byte.
`timescale 1ns/10ps
`include "ddr2_pin_defs.svh"

module ddr2_pin_device
#(
  parameter int DATA_WIDTH = 16,
  parameter int ADDR_WIDTH = 14,
  parameter int DEPTH      = 16
)
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      diff_clock_in,
  input  wire logic                      chip_select_n,
  input  wire logic                      row_strobe_n,
  input  wire logic                      column_strobe_n,
  input  wire logic                      write_enable_n,
  input  wire logic                      clock_enable,
  input  wire logic                      termination_enable,
  input  wire logic [1:0]                bank_select,
  input  wire logic [ADDR_WIDTH-1:0]     address_lines,
  input  wire logic [DATA_WIDTH-1:0]     data_lines_in,
  input  wire logic [DATA_WIDTH/8-1:0]   write_mask,
  output logic      [DATA_WIDTH-1:0]     data_lines_out_rise,
  output logic      [DATA_WIDTH-1:0]     data_lines_out_fall,
  output logic                           data_lines_oe,
  output logic      [DATA_WIDTH/8-1:0]   data_strobe_out,
  output logic      [DATA_WIDTH/8-1:0]   data_strobe_oe,
  output logic      [DATA_WIDTH/8-1:0]   data_strobe_comp_oe,
  output logic                           redundant_read_strobe_oe,
  output logic                           termination_on,
  output logic      [3:0]                bank_row_open,
  output logic      [ADDR_WIDTH-1:0]     extended_mode_reg_one,
  output logic                           cmd_event,
  output logic      [3:0]                cmd_code,
  output logic      [1:0]                cmd_bank,
  output logic      [ADDR_WIDTH-1:0]     cmd_address,
  output logic                           cmd_overrun
);

  // ----------------------------------------------------------------
  // Parameters and state
  // ----------------------------------------------------------------

  localparam int LANES = DATA_WIDTH / 8;
  localparam int IDXW  = $clog2(DEPTH);
  localparam int WORDW = 4 + 2 + ADDR_WIDTH;
  localparam logic [IDXW-1:0] IDX_ONE = IDXW'(1);
  localparam logic [IDXW-1:0] IDX_TWO = IDXW'(2);

  if (!(DATA_WIDTH == 8 || DATA_WIDTH == 16) || DEPTH < 8 ||
      (DEPTH & (DEPTH - 1)) != 0 || ADDR_WIDTH < 13 || ADDR_WIDTH > 14)
  begin : bad_parameters
    $error("ddr2_pin_device: unsupported width, depth or address size");
  end

  typedef struct packed {
    ddr2_pin_pkg::link_phase_type       phase;
    logic [2:0]                         pairs_left;
    logic [IDXW-1:0]                    index;
    logic [3:0][ADDR_WIDTH-1:0]         mode_regs;
    logic [3:0]                         row_open;
    logic [3:0][ADDR_WIDTH-1:0]         open_row;
    logic [DEPTH-1:0][DATA_WIDTH-1:0]   store;
    logic [DATA_WIDTH-1:0]              out_rise;
    logic [DATA_WIDTH-1:0]              out_fall;
    logic                               out_oe;
    logic [LANES-1:0]                   strobe;
    logic [LANES-1:0]                   strobe_oe;
    logic [LANES-1:0]                   comp_oe;
    logic                               rstrobe_oe;
    logic                               term_on;
    logic [WORDW-1:0]                   xfer_word;
    logic                               xfer_req;
    logic                               ack_meta;
    logic                               ack_sync;
    logic                               overrun;
  } link_type;

  typedef struct packed {
    logic                               req_meta;
    logic                               req_sync;
    logic                               req_seen;
    logic                               ovr_meta;
    logic                               ovr_sync;
    logic                               event_pulse;
    logic [WORDW-1:0]                   word;
  } sys_type;

  link_type                             link_reg;
  link_type                             link_next;
  sys_type                              sys_reg;
  sys_type                              sys_next;
  logic                                 link_rst_meta;
  logic                                 link_rst;
  logic [DATA_WIDTH+LANES-1:0]          beat_first;
  logic [DATA_WIDTH+LANES-1:0]          beat_second;

  // ----------------------------------------------------------------
  // Link reset and write beat capture
  // ----------------------------------------------------------------

  // Reset asserts at once in the link domain but releases on a link edge.
  always_ff @(posedge diff_clock_in or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link_rst_meta <= 1'b1;
      link_rst      <= 1'b1;
    end
    else
    begin
      link_rst_meta <= 1'b0;
      link_rst      <= link_rst_meta;
    end
  end

  // Write data is sampled at the strobe centres, which sit on the link clock edges.
  ddr_edge_capture
  #(
    .WIDTH (DATA_WIDTH + LANES)
  )
  beat_capture
  (
    .link_clk    (diff_clock_in),
    .link_rst    (link_rst),
    .beat_in     ({write_mask, data_lines_in}),
    .beat_first  (beat_first),
    .beat_second (beat_second)
  );

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------

  always_comb
  begin
    ddr2_pin_pkg::command_type cmd;
    logic [2:0]                pairs;
    logic                      mask_on;
    logic                      byte_wide;
    logic [ADDR_WIDTH-1:0]     emr_one;
    link_next = link_reg;
    cmd       = ddr2_pin_pkg::CMD_DESELECT;
    emr_one   = link_reg.mode_regs[1];
    byte_wide = (DATA_WIDTH == 8);
    pairs     = (link_reg.mode_regs[0][`BURST_FIELD_MSB:`BURST_FIELD_LSB] == `BURST_EIGHT_CODE)
              ? `PAIRS_BURST_EIGHT : `PAIRS_BURST_FOUR;
    mask_on   = !byte_wide || !emr_one[`MASK_OR_RSTROBE_BIT];

    // Commands count only with chip select low and clock enable high.
    if (!chip_select_n && clock_enable)
      cmd = ddr2_pin_pkg::command_type'({1'b0, row_strobe_n, column_strobe_n,
                                          write_enable_n});

    link_next.term_on = termination_enable &&
                        (emr_one[`TERM_LOW_BIT] || emr_one[`TERM_HIGH_BIT]);

    link_next.out_oe     = 1'b0;
    link_next.strobe     = '0;
    link_next.strobe_oe  = '0;
    link_next.comp_oe    = '0;
    link_next.rstrobe_oe = 1'b0;

    case (link_reg.phase)
      ddr2_pin_pkg::LINK_WRITE_LEAD:
      begin
        link_next.phase = ddr2_pin_pkg::LINK_WRITE;
      end
      ddr2_pin_pkg::LINK_WRITE:
      begin
        for (int l = 0; l < LANES; l++)
        begin
          if (!(mask_on && beat_first[DATA_WIDTH + l]))
            link_next.store[link_reg.index][l*8 +: 8] = beat_first[l*8 +: 8];
          if (!(mask_on && beat_second[DATA_WIDTH + l]))
            link_next.store[link_reg.index + IDX_ONE][l*8 +: 8] = beat_second[l*8 +: 8];
        end
        link_next.index      = link_reg.index + IDX_TWO;
        link_next.pairs_left = link_reg.pairs_left - 3'h1;
        if (link_reg.pairs_left == 3'h1)
          link_next.phase = ddr2_pin_pkg::LINK_IDLE;
      end
      ddr2_pin_pkg::LINK_READ:
      begin
        if (link_reg.pairs_left != 3'h0)
        begin
          // The strobe rises with the first beat of each pair: edge aligned.
          link_next.out_rise   = link_reg.store[link_reg.index];
          link_next.out_fall   = link_reg.store[link_reg.index + IDX_ONE];
          link_next.out_oe     = 1'b1;
          link_next.strobe     = '1;
          link_next.strobe_oe  = '1;
          link_next.comp_oe    = emr_one[`STROBE_COMP_OFF_BIT] ? '0 : '1;
          link_next.rstrobe_oe = byte_wide && emr_one[`MASK_OR_RSTROBE_BIT];
          link_next.index      = link_reg.index + IDX_TWO;
          link_next.pairs_left = link_reg.pairs_left - 3'h1;
        end
        else
        begin
          link_next.phase = ddr2_pin_pkg::LINK_IDLE;
        end
      end
      default:
      begin
        link_next.phase = ddr2_pin_pkg::LINK_IDLE;
      end
    endcase

    case (cmd)
      ddr2_pin_pkg::CMD_MODE_SET:
      begin
        link_next.mode_regs[bank_select] = address_lines;
      end
      ddr2_pin_pkg::CMD_PRECHARGE:
      begin
        if (address_lines[`PRECHARGE_ALL_BIT])
          link_next.row_open = 4'h0;
        else
          link_next.row_open[bank_select] = 1'b0;
      end
      ddr2_pin_pkg::CMD_ACTIVATE:
      begin
        link_next.row_open[bank_select] = 1'b1;
        link_next.open_row[bank_select] = address_lines;
      end
      ddr2_pin_pkg::CMD_WRITE,
      ddr2_pin_pkg::CMD_READ:
      begin
        // A burst already in flight keeps the data pins; the new access is dropped.
        if (link_reg.phase == ddr2_pin_pkg::LINK_IDLE)
        begin
          link_next.phase      = (cmd == ddr2_pin_pkg::CMD_READ)
                               ? ddr2_pin_pkg::LINK_READ : ddr2_pin_pkg::LINK_WRITE_LEAD;
          link_next.pairs_left = pairs;
          link_next.index      = address_lines[IDXW-1:0];
          if (address_lines[`AUTO_PRECHARGE_BIT])
            link_next.row_open[bank_select] = 1'b0;
        end
      end
      default:
      begin
      end
    endcase

    // Each accepted command other than a NOP is reported once across to the system clock if no report is in flight; otherwise overrun is set.
    if (cmd != ddr2_pin_pkg::CMD_DESELECT && cmd != ddr2_pin_pkg::CMD_NOP)
    begin
      if (link_reg.xfer_req == link_reg.ack_sync)
      begin
        link_next.xfer_word = {cmd, bank_select, address_lines};
        link_next.xfer_req  = !link_reg.xfer_req;
      end
      else
      begin
        link_next.overrun = 1'b1;
      end
    end

    link_next.ack_meta = sys_reg.req_seen;
    link_next.ack_sync = link_reg.ack_meta;
  end

  always_ff @(posedge diff_clock_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      link_reg           <= '0;
      link_reg.phase     <= ddr2_pin_pkg::LINK_IDLE;
      link_reg.mode_regs <= {4{`MODE_REG_RESET}};
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------

  always_comb
  begin
    sys_next             = sys_reg;
    sys_next.req_meta    = link_reg.xfer_req;
    sys_next.req_sync    = sys_reg.req_meta;
    sys_next.req_seen    = sys_reg.req_sync;
    sys_next.ovr_meta    = link_reg.overrun;
    sys_next.ovr_sync    = sys_reg.ovr_meta;
    sys_next.event_pulse = sys_reg.req_sync != sys_reg.req_seen;
    // The word is stable here: the link side holds it until the toggle returns.
    if (sys_reg.req_sync != sys_reg.req_seen)
      sys_next.word = link_reg.xfer_word;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sys_reg <= '0;
    else
      sys_reg <= sys_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign data_lines_out_rise      = link_reg.out_rise;
  assign data_lines_out_fall      = link_reg.out_fall;
  assign data_lines_oe            = link_reg.out_oe;
  assign data_strobe_out          = link_reg.strobe;
  assign data_strobe_oe           = link_reg.strobe_oe;
  assign data_strobe_comp_oe      = link_reg.comp_oe;
  assign redundant_read_strobe_oe = link_reg.rstrobe_oe;
  assign termination_on           = link_reg.term_on;
  assign bank_row_open            = link_reg.row_open;
  assign extended_mode_reg_one    = link_reg.mode_regs[1];
  assign cmd_event                = sys_reg.event_pulse;
  assign cmd_code                 = sys_reg.word[WORDW-1 -: 4];
  assign cmd_bank                 = sys_reg.word[ADDR_WIDTH +: 2];
  assign cmd_address              = sys_reg.word[ADDR_WIDTH-1:0];
  assign cmd_overrun              = sys_reg.ovr_sync;

endmodule // ddr2_pin_device

// >>> verilog/ddr_edge_capture.sv
// Captures a bus on both link clock edges and presents each beat pair together.
`timescale 1ns/10ps

module ddr_edge_capture
#(
  parameter int WIDTH = 18
)
(
  input  wire logic             link_clk,
  input  wire logic             link_rst,
  input  wire logic [WIDTH-1:0] beat_in,
  output logic      [WIDTH-1:0] beat_first,
  output logic      [WIDTH-1:0] beat_second
);

  logic [WIDTH-1:0] fall_reg;

  // The first beat is taken on the falling edge and held for the next rise.
  always_ff @(negedge link_clk or posedge link_rst)
  begin
    if (link_rst)
      fall_reg <= '0;
    else
      fall_reg <= beat_in;
  end

  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      beat_first  <= '0;
      beat_second <= '0;
    end
    else
    begin
      beat_first  <= fall_reg;
      beat_second <= beat_in;
    end
  end

endmodule // ddr_edge_capture
